// >>> hdl/pmbtam_pkg.sv
// pmbtam_pkg: constants, command codes and carrier types of the PMBus target block
// assumes: 125 MHz system clock, bus pins arrive asynchronously
package pmbtam_pkg;
  localparam int  CLK_MHZ          = 125;
  localparam int  STORE_WAIT_MS    = 5;
  localparam int  STORE_WAIT_CYC   = STORE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int  STRAP_MULT       = 8;
  localparam int  STRAP_SHIFT      = 3;
  localparam logic [6:0] ADDR_RESERVED_A = 7'h00;
  localparam logic [6:0] ADDR_RESERVED_B = 7'h0B;
  localparam logic [6:0] ADDR_RESERVED_C = 7'h0C;
  localparam logic [6:0] ADDR_FALLBACK   = 7'h7F;
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_ALERT_MASK     = 8'h1B;
  localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
  localparam logic [7:0] CMD_READ_VIN       = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT      = 8'h8B;
  localparam logic [7:0] CMD_READ_IOUT      = 8'h8C;
  localparam logic [7:0] CMD_READ_TEMP      = 8'h8D;
  localparam logic [7:0] CMD_READ_DUTY      = 8'h94;
  localparam logic [7:0] CMD_READ_FREQ      = 8'h95;
  localparam logic [7:0] CMD_TEMP_SELECT    = 8'hDC;
  localparam logic [7:0] CMD_ADDR_OFFSET    = 8'hE0;
  localparam logic [7:0] MASK_RESET         = 8'h00;
  localparam logic [7:0] TSEL_RESET         = 8'h00;
  localparam logic [7:0] AOFS_RESET         = 8'h00;
  localparam int         BUSY_BIT           = 7;
  localparam int         ALERT_BIT          = 0;
  localparam logic [3:0] BIT_LAST           = 4'h7;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp_int;
    logic [15:0] temp_ext;
    logic [15:0] freq;
    logic [15:0] duty;
  } pmbtam_meas_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_ACK  = 7'b0000100,
    ST_RX   = 7'b0001000,
    ST_TX   = 7'b0010000,
    ST_TACK = 7'b0100000,
    ST_SKIP = 7'b1000000
  } pmbtam_state_t;
endpackage

// >>> hdl/pmbtam_strap.sv
// pmbtam_strap: resolves the bus address from two strap indices
// assumes: indices already digitised and stable, sampled by the caller
module pmbtam_strap
  import pmbtam_pkg::*;
(
  input  wire logic [2:0] idx_high,
  input  wire logic [2:0] idx_low,
  input  wire logic       single_pin,
  output logic      [6:0] addr
);
  logic [6:0] raw;
  always_comb begin
    // single pin mode drops the low strap contribution
    raw = {1'b0, idx_high, STRAP_SHIFT'(0)} + (single_pin ? 7'h00 : {4'h0, idx_low});
    if (raw == ADDR_RESERVED_A || raw == ADDR_RESERVED_B || raw == ADDR_RESERVED_C) begin
      addr = ADDR_FALLBACK;
    end else begin
      addr = raw;
    end
  end
endmodule

// >>> hdl/pmbtam_top.sv
// pmbtam_top: PMBus target with strap addressing, monitoring reads and alert line
// assumes: open-drain scl/sda resolved outside; strap indices come from an analog digitiser
// What this block does
// - bus runs only at 100 kHz or 400 kHz; sampling at 125 MHz covers both.
// - each strap pin gives a 3-bit index from its resistor value.
// - address is eight times the high strap index plus the low one while aofs[0] is clear.
// - computed address 0, 11 or 12 becomes address 127.
// - any detected fault not masked in alert_mask pulls the alert line.
// - standard SMBus protocol; device never stretches the clock (scl_oe held at 0).
// - busy flag is set in status when the device cannot serve.
// - monitoring reads return current measurements at any time.
// - temperature read reports the sensor chosen by command 0xDC.
// - address-offset setting makes only the high strap contribute.
// - defaults come from non-volatile memory; settings rewritable over the bus.
// - behaves as a PMBus 1.3 target usable by any two-wire host.
// - alert goes low on any enabled fault or warning.
// - alert stays until clear-faults or re-enable; mask blocks chosen sources.
module pmbtam_top
  import pmbtam_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_WAIT_CYC
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         scl_in,
  output logic              scl_oe,
  input  wire logic         sda_in,
  output logic              sda_oe,
  output logic              fault_alert_line_oe,
  input  wire logic   [2:0] addr_strap_high,
  input  wire logic   [2:0] addr_strap_low,
  input  wire logic   [7:0] nvm_mask,
  input  wire logic   [7:0] nvm_tsel,
  input  wire logic   [7:0] nvm_aofs,
  input  wire pmbtam_meas_t meas,
  input  wire logic   [7:0] fault_src,
  input  wire logic         output_reenable,
  output logic              nvm_store,
  output logic        [7:0] cfg_mask,
  output logic              busy,
  output logic        [6:0] own_addr
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_s, sda_s;
  logic       scl_d, sda_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // ----------------------------------------------------------------
  // configuration and address
  // ----------------------------------------------------------------
  logic [7:0] alert_mask, tsel, aofs;
  logic       cfg_loaded;
  pmbtam_strap u_strap (
    .idx_high   (addr_strap_high),
    .idx_low    (addr_strap_low),
    .single_pin (aofs[0]),
    .addr       (own_addr)
  );

  // ----------------------------------------------------------------
  // transaction engine
  // ----------------------------------------------------------------
  pmbtam_state_t state, next_state;
  logic [3:0]  bitc, next_bitc;
  logic [7:0]  sh, next_sh;
  logic [7:0]  cmd, next_cmd;
  logic [1:0]  bytec, next_bytec;
  logic        rnw, next_rnw;
  logic        sda_o, next_sda_o;
  logic [7:0]  next_mask, next_tsel, next_aofs;
  logic        clr_pulse;
  logic [31:0] store_cnt, next_store_cnt;
  logic [15:0] rd_word;
  logic [7:0]  status_byte;

  assign busy        = (store_cnt != 32'h0);
  assign status_byte = {busy, 6'h00, fault_alert_line_oe};
  assign nvm_store   = (store_cnt == STORE_CYCLES[31:0]);
  assign cfg_mask    = alert_mask;

  always_comb begin
    case (cmd)
      CMD_READ_VIN:    rd_word = meas.vin;
      CMD_READ_VOUT:   rd_word = meas.vout;
      CMD_READ_IOUT:   rd_word = meas.iout;
      CMD_READ_TEMP:   rd_word = tsel[0] ? meas.temp_ext : meas.temp_int;
      CMD_READ_FREQ:   rd_word = meas.freq;
      CMD_READ_DUTY:   rd_word = meas.duty;
      CMD_STATUS_BYTE: rd_word = {8'h00, status_byte};
      CMD_ALERT_MASK:  rd_word = {8'h00, alert_mask};
      CMD_TEMP_SELECT: rd_word = {8'h00, tsel};
      CMD_ADDR_OFFSET: rd_word = {8'h00, aofs};
      default:         rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    next_state     = state;
    next_bitc      = bitc;
    next_sh        = sh;
    next_cmd       = cmd;
    next_bytec     = bytec;
    next_rnw       = rnw;
    next_sda_o     = sda_o;
    next_mask      = alert_mask;
    next_tsel      = tsel;
    next_aofs      = aofs;
    next_store_cnt = (store_cnt != 32'h0) ? store_cnt - 32'h1 : 32'h0;
    clr_pulse      = 1'b0;
    if (!cfg_loaded) begin
      next_mask = nvm_mask;
      next_tsel = nvm_tsel;
      next_aofs = nvm_aofs;
    end
    if (start_c) begin
      next_state = ST_ADDR;
      next_bitc  = 4'h0;
      next_sda_o = 1'b0;
      next_bytec = 2'b00;
    end else if (stop_c) begin
      next_state = ST_IDLE;
      next_sda_o = 1'b0;
    end else begin
      case (state)
        ST_IDLE: next_sda_o = 1'b0;
        ST_ADDR: begin
          if (scl_rise) begin
            next_sh   = {sh[6:0], sda_s[1]};
            next_bitc = bitc + 4'h1;
          end
          if (scl_fall && bitc == BIT_LAST + 4'h1) begin
            if (sh[7:1] == own_addr) begin
              next_rnw   = sh[0];
              next_sda_o = 1'b1;
              next_state = ST_ACK;
            end else begin
              next_state = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_bitc = 4'h0;
            if (rnw) begin
              next_sh    = (bytec == 2'b00) ? rd_word[7:0] : rd_word[15:8];
              next_sda_o = ~((bytec == 2'b00) ? rd_word[7] : rd_word[15]);
              next_state = ST_TX;
            end else begin
              next_sda_o = 1'b0;
              next_state = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_sh   = {sh[6:0], sda_s[1]};
            next_bitc = bitc + 4'h1;
          end
          if (scl_fall && bitc == BIT_LAST + 4'h1) begin
            next_sda_o = 1'b1;
            next_state = ST_ACK;
            next_bytec = (bytec == 2'b11) ? bytec : bytec + 2'b01;
            if (bytec == 2'b00) begin
              next_cmd = sh;
              if (sh == CMD_CLEAR_FAULTS) begin
                clr_pulse = 1'b1;
              end
              if (sh == CMD_STORE_USER_ALL) begin
                next_store_cnt = STORE_CYCLES[31:0];
              end
            end else if (bytec == 2'b01) begin
              // writes are taken from the first data byte
              case (cmd)
                CMD_ALERT_MASK:  next_mask = sh;
                CMD_TEMP_SELECT: next_tsel = sh;
                CMD_ADDR_OFFSET: next_aofs = sh;
                default:         next_mask = alert_mask;
              endcase
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitc == BIT_LAST) begin
              next_sda_o = 1'b0;
              next_state = ST_TACK;
            end else begin
              next_sh    = {sh[6:0], 1'b0};
              next_sda_o = ~sh[6];
              next_bitc  = bitc + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            if (sda_s[1]) begin
              next_state = ST_SKIP;
            end else begin
              next_bytec = bytec + 2'b01;
              next_state = ST_ACK;
            end
          end
        end
        ST_SKIP: next_sda_o = 1'b0;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      bitc       <= 4'h0;
      sh         <= 8'h00;
      cmd        <= 8'h00;
      bytec      <= 2'b00;
      rnw        <= 1'b0;
      sda_o      <= 1'b0;
      alert_mask <= MASK_RESET;
      tsel       <= TSEL_RESET;
      aofs       <= AOFS_RESET;
      cfg_loaded <= 1'b0;
      store_cnt  <= 32'h0;
    end else begin
      state      <= next_state;
      bitc       <= next_bitc;
      sh         <= next_sh;
      cmd        <= next_cmd;
      bytec      <= next_bytec;
      rnw        <= next_rnw;
      sda_o      <= next_sda_o;
      alert_mask <= next_mask;
      tsel       <= next_tsel;
      aofs       <= next_aofs;
      cfg_loaded <= 1'b1;
      store_cnt  <= next_store_cnt;
    end
  end
  assign sda_oe = sda_o;
  // ack phases never stretch; no clock holding needed at 100/400 kHz
  assign scl_oe = 1'b0;

  // ----------------------------------------------------------------
  // alert latch
  // ----------------------------------------------------------------
  logic [7:0] fault_lat, next_fault_lat;
  always_comb begin
    // a new fault in the clearing cycle survives the clear
    next_fault_lat = (clr_pulse || output_reenable) ? 8'h00 : fault_lat;
    next_fault_lat = next_fault_lat | (fault_src & ~alert_mask);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_lat           <= 8'h00;
      fault_alert_line_oe <= 1'b0;
    end else begin
      fault_lat           <= next_fault_lat;
      fault_alert_line_oe <= |next_fault_lat;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESERVED_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    (aofs[0] == 1'b0 && addr_strap_high == 3'h1 && addr_strap_low == 3'h3) |-> own_addr == ADDR_FALLBACK)
    else $error("reserved address not remapped");
  AST_ADDR_SUM: assert property (@(posedge clk) disable iff (!resetn)
    (aofs[0] == 1'b0 && addr_strap_high == 3'h5 && addr_strap_low == 3'h2) |-> own_addr == 7'h2A)
    else $error("address not eight times high plus low");
  AST_SINGLE_PIN: assert property (@(posedge clk) disable iff (!resetn)
    (aofs[0] && addr_strap_high == 3'h3) |-> own_addr == 7'h18)
    else $error("single pin address wrong");
  AST_ALERT_SET: assert property (@(posedge clk) disable iff (!resetn)
    (|(fault_src & ~alert_mask)) |=> fault_alert_line_oe)
    else $error("alert not raised for enabled fault");
  AST_ALERT_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (fault_alert_line_oe && !clr_pulse && !output_reenable) |=> fault_alert_line_oe)
    else $error("alert dropped without clear");
  AST_ALERT_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    (output_reenable && fault_src == 8'h00) |=> !fault_alert_line_oe)
    else $error("alert not cleared on re-enable");
  AST_BUSY_STORE: assert property (@(posedge clk) disable iff (!resetn)
    (clr_pulse == 1'b0 && $rose(nvm_store)) |-> busy ##1 busy)
    else $error("busy not held during store");
  AST_NO_FOREIGN_ACK: assert property (@(posedge clk) disable iff (!resetn)
    (state == ST_SKIP) |-> !sda_oe)
    else $error("drove sda for foreign address");
  AST_TEMP_SEL: assert property (@(posedge clk) disable iff (!resetn)
    (cmd == CMD_READ_TEMP && tsel[0]) |-> rd_word == meas.temp_ext)
    else $error("wrong temperature sensor");
  COV_ACK: cover property (@(posedge clk) disable iff (!resetn) state == ST_ADDR ##1 state == ST_ACK);
  COV_READ: cover property (@(posedge clk) disable iff (!resetn) state == ST_TX);
  COV_ALERT: cover property (@(posedge clk) disable iff (!resetn) $rose(fault_alert_line_oe));
  COV_STORE: cover property (@(posedge clk) disable iff (!resetn) $rose(busy));
endmodule

// >>> test/pmbtam_host_model.sv
// pmbtam_host_model: two-wire bus host driving the target over scl and sda
// assumes: bench resolves both open-drain wires with pull-ups; bus bit time of 80 ns
module pmbtam_host_model (
  input  wire logic clk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_drv,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus conditions and bit transfers
  // ----------------------------------------
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // packet error check: crc-8 over x^8+x^2+x+1, folded in one byte at a time
  function automatic logic [7:0] pec_step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] r;
    r = crc ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic hp();
    repeat (5) @(negedge clk);
  endtask
  task automatic start();
    sda_drv = 1'b1;
    hp();
    scl_drv = 1'b1;
    hp();
    sda_drv = 1'b0;
    hp();
    scl_drv = 1'b0;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    hp();
    scl_drv = 1'b1;
    hp();
    sda_drv = 1'b1;
    repeat (4) hp();
  endtask
  task automatic bit_x(input logic b, output logic s);
    sda_drv = b;
    hp();
    scl_drv = 1'b1;
    // a stretched clock holds the bit until the target lets go
    while (scl_w !== 1'b1) @(negedge clk);
    hp();
    s = sda_w;
    scl_drv = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, s);
  endtask
endmodule

// >>> test/test_pmbtam_top.sv
// test_pmbtam_top: self-checking bench for the PMBus target block
// assumes: package, design and host model compiled first; pull-ups on scl and sda
module test_pmbtam_top import pmbtam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  // shortened store wait so busy can be watched within one read
  localparam int STORE_SIM = 1000;
  // nvm default differs from the reset value so that the load after reset is visible
  localparam logic [7:0] NVM_MASK_SIM = 8'h80;
  logic         clk, resetn, scl_oe, sda_oe, alert_oe, host_scl, host_sda, reen, nvm_store, busy;
  logic   [2:0] s_hi, s_lo;
  logic   [6:0] own_addr, tgt;
  logic   [7:0] fsrc, cfg_mask;
  pmbtam_meas_t meas;
  int           n_fail = 0, checks_done = 0, n_store = 0;
  wire          scl_w = host_scl & ~scl_oe;
  wire          sda_w = host_sda & ~sda_oe;
  pmbtam_top #(.STORE_CYCLES(STORE_SIM)) u_pmbtam_top (.clk(clk), .resetn(resetn), .scl_in(scl_w),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe), .fault_alert_line_oe(alert_oe), .addr_strap_high(s_hi),
    .addr_strap_low(s_lo), .nvm_mask(NVM_MASK_SIM), .nvm_tsel(TSEL_RESET), .nvm_aofs(AOFS_RESET), .meas(meas),
    .fault_src(fsrc), .output_reenable(reen), .nvm_store(nvm_store), .cfg_mask(cfg_mask), .busy(busy),
    .own_addr(own_addr));
  pmbtam_host_model u_pmbtam_host_model (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_drv(host_scl),
    .sda_drv(host_sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // counted on the falling edge, mid-pulse, so the one-cycle pulse is seen exactly once
  always @(negedge clk) if (nvm_store === 1'b1) n_store++;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input bit has_d, output logic ok);
    logic       a0, a1, a2, a3;
    logic [7:0] pec;
    u_pmbtam_host_model.start();
    u_pmbtam_host_model.wbyte({tgt, 1'b0}, a0);
    u_pmbtam_host_model.wbyte(cmd, a1);
    pec = u_pmbtam_host_model.pec_step(u_pmbtam_host_model.pec_step(8'h00, {tgt, 1'b0}), cmd);
    a2 = 1'b1;
    if (has_d) begin
      u_pmbtam_host_model.wbyte(d, a2);
      pec = u_pmbtam_host_model.pec_step(pec, d);
    end
    u_pmbtam_host_model.wbyte(pec, a3);
    u_pmbtam_host_model.stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] w, output logic ok);
    logic a0, a1, a2;
    u_pmbtam_host_model.start();
    u_pmbtam_host_model.wbyte({tgt, 1'b0}, a0);
    u_pmbtam_host_model.wbyte(cmd, a1);
    u_pmbtam_host_model.start();
    u_pmbtam_host_model.wbyte({tgt, 1'b1}, a2);
    u_pmbtam_host_model.rbyte(1'b0, w[7:0]);
    u_pmbtam_host_model.rbyte(1'b1, w[15:8]);
    u_pmbtam_host_model.stop();
    ok = a0 & a1 & a2;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_strap();
    logic [5:0]  cmb [6] = '{6'h00, 6'h0B, 6'h0C, 6'h2A, 6'h3F, 6'h15};
    logic [6:0]  exp [6] = '{7'h7F, 7'h7F, 7'h7F, 7'h2A, 7'h3F, 7'h15};
    logic [15:0] w;
    logic        ok;
    // the last combination leaves the straps at the bench's own address
    for (int i = 0; i < 6; i++) begin
      {s_hi, s_lo} = cmb[i];
      repeat (2) @(negedge clk);
      chk("own_addr", own_addr, exp[i]);
    end
    tgt = 7'h16;
    rd(CMD_READ_VIN, w, ok);
    chk("foreign ack", ok, 0);
    tgt = 7'h15;
    rd(CMD_READ_VIN, w, ok);
    chk("own ack", ok, 1);
    $display("test strap done");
  endtask
  task automatic t_read();
    logic [7:0]  cmds [6] = '{CMD_READ_VIN, CMD_READ_VOUT, CMD_READ_IOUT, CMD_READ_TEMP, CMD_READ_FREQ,
      CMD_READ_DUTY};
    logic [15:0] exp [6];
    logic [15:0] w;
    logic        ok;
    exp = '{meas.vin, meas.vout, meas.iout, meas.temp_int, meas.freq, meas.duty};
    for (int i = 0; i < 6; i++) begin
      rd(cmds[i], w, ok);
      chk("read ack", ok, 1);
      chk("read word", w, exp[i]);
    end
    meas.vin = 16'hBEEF;
    rd(CMD_READ_VIN, w, ok);
    chk("fresh vin", w, 16'hBEEF);
    $display("test read done");
  endtask
  task automatic t_temp();
    logic [15:0] w;
    logic        ok;
    wr(CMD_TEMP_SELECT, 8'h01, 1, ok);
    chk("write ack", ok, 1);
    rd(CMD_TEMP_SELECT, w, ok);
    chk("tsel read", w, 16'h0001);
    rd(CMD_READ_TEMP, w, ok);
    chk("temp ext", w, meas.temp_ext);
    wr(CMD_TEMP_SELECT, 8'h00, 1, ok);
    rd(CMD_READ_TEMP, w, ok);
    chk("temp int", w, meas.temp_int);
    $display("test temp done");
  endtask
  task automatic t_alert();
    logic [15:0] w;
    logic        ok;
    chk("alert idle", alert_oe, 0);
    fsrc = 8'h01;
    repeat (2) @(negedge clk);
    chk("alert on", alert_oe, 1);
    fsrc = 8'h00;
    repeat (20) @(negedge clk);
    chk("alert held", alert_oe, 1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 0, ok);
    chk("alert cleared", alert_oe, 0);
    wr(CMD_ALERT_MASK, 8'h01, 1, ok);
    chk("cfg_mask", cfg_mask, 8'h01);
    rd(CMD_ALERT_MASK, w, ok);
    chk("mask read", w, 16'h0001);
    fsrc = 8'h01;
    repeat (2) @(negedge clk);
    chk("alert masked", alert_oe, 0);
    fsrc = 8'h02;
    repeat (2) @(negedge clk);
    chk("alert other", alert_oe, 1);
    rd(CMD_STATUS_BYTE, w, ok);
    chk("status alert", w[ALERT_BIT], 1);
    fsrc = 8'h00;
    reen = 1'b1;
    @(negedge clk);
    reen = 1'b0;
    repeat (2) @(negedge clk);
    chk("alert reenable", alert_oe, 0);
    $display("test alert done");
  endtask
  task automatic t_store();
    logic [15:0] w;
    logic        ok;
    n_store = 0;
    wr(CMD_STORE_USER_ALL, 8'h00, 0, ok);
    chk("store pulses", n_store, 1);
    chk("busy", busy, 1);
    rd(CMD_STATUS_BYTE, w, ok);
    chk("status busy", w[BUSY_BIT], 1);
    for (int i = 0; i < STORE_SIM && busy !== 1'b0; i++) @(negedge clk);
    chk("busy end", busy, 0);
    rd(CMD_STATUS_BYTE, w, ok);
    chk("status free", w[BUSY_BIT], 0);
    $display("test store done");
  endtask
  task automatic t_single();
    logic [15:0] w;
    logic        ok;
    wr(CMD_ADDR_OFFSET, 8'h01, 1, ok);
    repeat (2) @(negedge clk);
    chk("single addr", own_addr, 7'h10);
    tgt = 7'h10;
    rd(CMD_READ_VIN, w, ok);
    chk("single ack", ok, 1);
    rd(CMD_ADDR_OFFSET, w, ok);
    chk("aofs read", w, 16'h0001);
    s_hi = 3'h3;
    repeat (2) @(negedge clk);
    chk("single addr 3", own_addr, 7'h18);
    s_hi = 3'h0;
    repeat (2) @(negedge clk);
    chk("single reserved", own_addr, 7'h7F);
    $display("test single done");
  endtask
  initial begin
    resetn = 1'b0;
    {s_hi, s_lo} = 6'h15;
    tgt = 7'h15;
    fsrc = 8'h00;
    reen = 1'b0;
    meas = {16'h1101, 16'h2202, 16'h3303, 16'h4404, 16'h5505, 16'h6606, 16'h7707};
    repeat (6) @(negedge clk);
    chk("reset mask", cfg_mask, MASK_RESET);
    chk("reset busy", busy, 0);
    chk("reset sda", sda_oe, 0);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    chk("nvm mask", cfg_mask, NVM_MASK_SIM);
    t_strap();
    t_read();
    t_temp();
    t_alert();
    t_store();
    t_single();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
